// *** common/serr_pkg.sv ***
// package: constants for the receiver error handling and status output stage
package serr_pkg;
	// clock and timing
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned HOLD_MS = 45; // least fault hold time
	localparam int unsigned HOLD_CYCLES = HOLD_MS * CLK_KHZ;
	// parity error runs
	localparam logic [3:0] ERR_LONG_RUN = 4'h9;
	localparam logic [3:0] ERR_CNT_MAX = 4'hf;
	// channel status layout
	localparam int unsigned CS_BITS = 192;
	localparam logic [7:0] CS_IDX_NONPCM = 8'h01;
	localparam logic [7:0] CS_IDX_EMPH = 8'h03;
	localparam logic [7:0] CS_IDX_FS_LO = 8'h18;
	localparam logic [7:0] CS_IDX_FS_HI = 8'h1b;
	localparam logic [7:0] CS_IDX_LAST = 8'hbf;
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FS = 8'h08;
	// control field positions
	localparam int unsigned CT_OR_LO = 0; // nonaudio_or_select[1:0]
	localparam int unsigned CT_VPIN = 2; // validity_pin_select
	localparam int unsigned CT_UPIN = 3; // user_pin_select
	localparam int unsigned CT_BS_LO = 4; // block_sync_select_lo
	localparam int unsigned CT_BS_HI = 5; // block_sync_select_hi
	localparam int unsigned CT_IRQ = 6; // burst_irq_source
	localparam logic [6:0] CTRL_RESET = 7'h00;
	// lock supervisor states, one-hot
	typedef enum logic [2:0] {
		LK_RUN = 3'b001,
		LK_HOLD = 3'b010,
		LK_RESUME = 3'b100
	} serr_lock_t;
endpackage

// *** rtl/serr_top.sv ***
// module: error substitution, mute, recovery and status pin outputs
//
// Function
// - runs of up to 8 parity errors on PCM reuse last good L/R sample
// - short error runs on non-PCM data pass the words through unchanged
// - PCM or non-PCM is decided by status bit 1 from before the errors
// - audio is muted on lock loss or on 9 or more errors in a row
// - during short runs status bits keep the previous block's value per bit
// - long runs force audio, status, validity, user low; fs result stays
// - short runs keep validity and user live and hold channel status
// - lock error forces audio, fs result, status, validity, user low
// - seeing block, left and right preambles counts as lock regained
// - audio resumes at first word clock edge after the fault flag falls
// - non-audio flag follows status bit 1 at once, even during fault
// - non-audio flag may be ORed with the burst or surround flag
// - pre-emphasis flag follows status bit 3 of error-free subframes at once, even during fault
// - validity pin shows each subframe's validity bit when selected
// - validity leads its audio word by half to one frame
// - user pin select works only while high block-sync select is 0
// - high block-sync select puts serial status bits on the shared pin
// - receive block start is high only while status bit 0 is output
// - block start pin carries receive or transmit sync, never both
// - burst or surround sync raises the interrupt when enabled
// - burst sync is searched only while status bit 1 says non-PCM
// - surround needs sync and base rate; extension needs core first
// - burst flags clear on fs change, lock error or data error
// - fault flag rises on lock or data error, word aligned except in resume, then held
// - a changed fs field in status raises the fault flag at once
`timescale 1ns/100ps
module serr_top #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned HOLD_CYC = serr_pkg::HOLD_CYCLES
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	// subframes from the demodulator
	input wire logic SUB_VALID,
	input wire logic SUB_RIGHT,
	input wire logic SUB_BLOCK,
	input wire logic [WIDTH-1:0] SUB_DATA,
	input wire logic SUB_PAR_ERR,
	input wire logic SUB_VBIT,
	input wire logic SUB_UBIT,
	input wire logic SUB_CBIT,
	input wire logic PLL_LOCKED,
	input wire logic PREAMBLES_SEEN,
	input wire logic [7:0] FS_RESULT,
	input wire logic FRAME_WORD_CLOCK,
	// sync detectors
	input wire logic BURST_SYNC,
	input wire logic SURR_SYNC,
	input wire logic SURR_BASE_OK,
	input wire logic SURR_EXT_SYNC,
	// other sources sharing the block start pin
	input wire logic TX_BLOCK_SYNC,
	input wire logic CLOCK_SWITCH_IN,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// outputs
	output logic [WIDTH-1:0] AUDIO_WORD,
	output logic AUDIO_STROBE,
	output logic AUDIO_RIGHT,
	output logic LOCK_FAULT_FLAG,
	output logic [7:0] FS_OUT,
	output logic NONAUDIO_FLAG,
	output logic PREEMPH_FLAG_OUT,
	output logic VALIDITY_OUT,
	output logic USER_BIT_OUT,
	output logic CHAN_STATUS_SERIAL_OUT,
	output logic AUDIO_VALIDITY_PIN,
	output logic EMPH_USER_CS_PIN,
	output logic BLOCK_START_OUT,
	output logic IRQ_OUT
);
	logic [6:0] ctrl_q;
	logic [3:0] err_cnt_q;
	logic [7:0] cs_idx_q;
	logic [serr_pkg::CS_BITS-1:0] cs_prev_q;
	logic [2:0] fs_cur_q;
	logic [3:0] fs_ref_q;
	logic fs_ref_ok_q;
	logic fs_chg;
	logic nonpcm_q;
	logic pcm_class_q;
	logic [WIDTH-1:0] good_l_q, good_r_q;
	logic [WIDTH-1:0] word_l_q, word_r_q;
	logic wclk_q;
	logic wclk_edge;
	logic [25:0] hold_q;
	serr_pkg::serr_lock_t lk_q;
	logic long_err;
	logic lock_err;
	logic fault_cause;
	logic muted;
	logic burst_q, surr_q, surr_ext_q;
	logic cs_bit;
	logic [3:0] err_next;

	// next run length; saturates so a long outage cannot wrap back to short
	assign err_next = (err_cnt_q == serr_pkg::ERR_CNT_MAX) ? err_cnt_q
		: err_cnt_q + 4'h1;
	assign long_err = (err_cnt_q >= serr_pkg::ERR_LONG_RUN);
	assign lock_err = !PLL_LOCKED;
	assign fault_cause = lock_err | long_err;
	assign wclk_edge = FRAME_WORD_CLOCK != wclk_q;
	// resume state is unmuted so its word edge already carries audio
	assign muted = (lk_q == serr_pkg::LK_HOLD) | long_err | lock_err;
	// status bit shown for this subframe: stale copy during a short run
	assign cs_bit = SUB_PAR_ERR ? cs_prev_q[cs_idx_q] : SUB_CBIT;

	// control register writes
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_q <= serr_pkg::CTRL_RESET;
		end else if (REG_WR && REG_ADDR == serr_pkg::OFS_CTRL) begin
			ctrl_q <= REG_WDATA[6:0];
		end
	end

	// register reads: data one cycle after the strobe, zero elsewhere
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			REG_RDATA <= 32'h0;
		end else if (!REG_RD) begin
			REG_RDATA <= 32'h0;
		end else if (REG_ADDR == serr_pkg::OFS_CTRL) begin
			REG_RDATA <= {25'h0, ctrl_q};
		end else if (REG_ADDR == serr_pkg::OFS_STATUS) begin
			REG_RDATA <= {24'h0, err_cnt_q, surr_ext_q, surr_q, burst_q,
				LOCK_FAULT_FLAG};
		end else if (REG_ADDR == serr_pkg::OFS_FS) begin
			REG_RDATA <= {24'h0, FS_OUT};
		end else begin
			REG_RDATA <= 32'h0;
		end
	end

	// consecutive parity error run length
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			err_cnt_q <= 4'h0;
		end else if (SUB_VALID) begin
			err_cnt_q <= SUB_PAR_ERR ? err_next : 4'h0;
		end
	end

	// position in the status block, restarted by the block preamble
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			cs_idx_q <= 8'h00;
		end else if (SUB_VALID && SUB_BLOCK && !SUB_RIGHT) begin
			cs_idx_q <= 8'h00;
		end else if (SUB_VALID && SUB_RIGHT) begin
			cs_idx_q <= (cs_idx_q == serr_pkg::CS_IDX_LAST) ? 8'h00
				: cs_idx_q + 8'h01;
		end
	end

	// previous block copy, updated per bit only from clean left subframes
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			cs_prev_q <= '0;
		end else if (SUB_VALID && !SUB_RIGHT && !SUB_PAR_ERR) begin
			cs_prev_q[cs_idx_q] <= SUB_CBIT;
		end
	end

	// fs field compare against the last block; fires at the field's end
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			fs_cur_q <= 3'h0;
			fs_ref_q <= 4'h0;
			fs_ref_ok_q <= 1'b0;
			fs_chg <= 1'b0;
		end else begin
			fs_chg <= 1'b0;
			if (lock_err) begin
				fs_ref_ok_q <= 1'b0; // a new source is not a change
			end else if (SUB_VALID && !SUB_RIGHT && !SUB_PAR_ERR) begin
				if (cs_idx_q >= serr_pkg::CS_IDX_FS_LO &&
					cs_idx_q < serr_pkg::CS_IDX_FS_HI) begin
					fs_cur_q <= {SUB_CBIT, fs_cur_q[2:1]};
				end else if (cs_idx_q == serr_pkg::CS_IDX_FS_HI) begin
					fs_ref_q <= {SUB_CBIT, fs_cur_q};
					fs_ref_ok_q <= 1'b1;
					fs_chg <= fs_ref_ok_q &&
						(fs_ref_q != {SUB_CBIT, fs_cur_q});
				end
			end
		end
	end

	// stream class: live bit 1 for the pins, pre-error copy for data
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			nonpcm_q <= 1'b0;
			pcm_class_q <= 1'b1;
		end else if (SUB_VALID && !SUB_RIGHT &&
			cs_idx_q == serr_pkg::CS_IDX_NONPCM) begin
			nonpcm_q <= SUB_CBIT;
			if (!SUB_PAR_ERR && err_cnt_q == 4'h0) begin
				pcm_class_q <= !SUB_CBIT;
			end
		end
	end

	// sample substitution per channel
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			good_l_q <= '0;
			good_r_q <= '0;
			word_l_q <= '0;
			word_r_q <= '0;
		end else if (SUB_VALID) begin
			if (!SUB_PAR_ERR) begin
				if (SUB_RIGHT) begin
					good_r_q <= SUB_DATA;
					word_r_q <= SUB_DATA;
				end else begin
					good_l_q <= SUB_DATA;
					word_l_q <= SUB_DATA;
				end
			end else if (pcm_class_q) begin
				// pcm: repeat last good sample of the same channel
				if (SUB_RIGHT) begin
					word_r_q <= good_r_q;
				end else begin
					word_l_q <= good_l_q;
				end
			end else if (SUB_RIGHT) begin
				word_r_q <= SUB_DATA;
			end else begin
				word_l_q <= SUB_DATA;
			end
		end
	end

	// word clock edge detect; the level is already synchronous
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			wclk_q <= 1'b0;
		end else begin
			wclk_q <= FRAME_WORD_CLOCK;
		end
	end

	// lock supervisor: raise on cause, hold, release on a word edge
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			lk_q <= serr_pkg::LK_RUN;
			hold_q <= 26'h0;
		end else begin
			case (lk_q)
				serr_pkg::LK_RUN: begin
					if (fs_chg || (fault_cause && wclk_edge)) begin
						lk_q <= serr_pkg::LK_HOLD;
						hold_q <= 26'(HOLD_CYC);
					end
				end
				serr_pkg::LK_HOLD: begin
					if (fault_cause || !PREAMBLES_SEEN) begin
						hold_q <= 26'(HOLD_CYC); // restart while still bad
					end else if (hold_q != 26'h0) begin
						hold_q <= hold_q - 26'h1;
					end else if (wclk_edge) begin
						lk_q <= serr_pkg::LK_RESUME;
					end
				end
				serr_pkg::LK_RESUME: begin
					if (fs_chg || fault_cause) begin
						lk_q <= serr_pkg::LK_HOLD;
						hold_q <= 26'(HOLD_CYC);
					end else if (wclk_edge) begin
						lk_q <= serr_pkg::LK_RUN;
					end
				end
				default: begin
					lk_q <= serr_pkg::LK_RUN;
				end
			endcase
		end
	end

	// serial audio word, one per word clock edge; low falls on left
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			AUDIO_WORD <= '0;
			AUDIO_STROBE <= 1'b0;
			AUDIO_RIGHT <= 1'b0;
		end else begin
			AUDIO_STROBE <= wclk_edge;
			if (wclk_edge) begin
				AUDIO_RIGHT <= FRAME_WORD_CLOCK;
				if (muted) begin
					AUDIO_WORD <= '0;
				end else begin
					AUDIO_WORD <= FRAME_WORD_CLOCK ? word_r_q : word_l_q;
				end
			end
		end
	end

	// fault flag and fs result pins
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			LOCK_FAULT_FLAG <= 1'b0;
			FS_OUT <= 8'h00;
		end else begin
			LOCK_FAULT_FLAG <= (lk_q == serr_pkg::LK_HOLD);
			FS_OUT <= lock_err ? 8'h00 : FS_RESULT;
		end
	end

	// per-subframe bits; sampled at arrival so they lead the audio word
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			VALIDITY_OUT <= 1'b0;
			USER_BIT_OUT <= 1'b0;
			CHAN_STATUS_SERIAL_OUT <= 1'b0;
		end else if (lock_err || long_err) begin
			VALIDITY_OUT <= 1'b0;
			USER_BIT_OUT <= 1'b0;
			CHAN_STATUS_SERIAL_OUT <= 1'b0;
		end else if (SUB_VALID) begin
			VALIDITY_OUT <= SUB_VBIT;
			USER_BIT_OUT <= SUB_UBIT;
			CHAN_STATUS_SERIAL_OUT <= cs_bit;
		end
	end

	// flags from live status, not gated by the fault flag
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			NONAUDIO_FLAG <= 1'b0;
			PREEMPH_FLAG_OUT <= 1'b0;
		end else begin
			case (ctrl_q[serr_pkg::CT_OR_LO +: 2])
				2'h1: NONAUDIO_FLAG <= nonpcm_q | burst_q;
				2'h2: NONAUDIO_FLAG <= nonpcm_q | surr_q;
				default: NONAUDIO_FLAG <= nonpcm_q;
			endcase
			if (SUB_VALID && !SUB_RIGHT && !SUB_PAR_ERR &&
				cs_idx_q == serr_pkg::CS_IDX_EMPH) begin
				PREEMPH_FLAG_OUT <= SUB_CBIT;
			end
		end
	end

	// shared pins; receive block sync owns the status pin when chosen
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			AUDIO_VALIDITY_PIN <= 1'b0;
			EMPH_USER_CS_PIN <= 1'b0;
			BLOCK_START_OUT <= 1'b0;
		end else begin
			AUDIO_VALIDITY_PIN <= ctrl_q[serr_pkg::CT_VPIN] ? VALIDITY_OUT
				: NONAUDIO_FLAG;
			if (ctrl_q[serr_pkg::CT_BS_HI]) begin
				EMPH_USER_CS_PIN <= CHAN_STATUS_SERIAL_OUT;
				BLOCK_START_OUT <= (cs_idx_q == 8'h00) && !muted;
			end else begin
				EMPH_USER_CS_PIN <= ctrl_q[serr_pkg::CT_UPIN] ? USER_BIT_OUT
					: PREEMPH_FLAG_OUT;
				// lo select picks transmit sync, otherwise clock switch
				BLOCK_START_OUT <= ctrl_q[serr_pkg::CT_BS_LO] ? TX_BLOCK_SYNC
					: CLOCK_SWITCH_IN;
			end
		end
	end

	// burst and surround detection; the clear wins, as a stale flag lies
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			burst_q <= 1'b0;
			surr_q <= 1'b0;
			surr_ext_q <= 1'b0;
		end else if (fs_chg || lock_err || long_err || LOCK_FAULT_FLAG) begin
			burst_q <= 1'b0;
			surr_q <= 1'b0;
			surr_ext_q <= 1'b0;
		end else begin
			if (BURST_SYNC && nonpcm_q) begin
				burst_q <= 1'b1;
			end
			if (SURR_SYNC && SURR_BASE_OK) begin
				surr_q <= 1'b1;
			end
			if (surr_q && SURR_EXT_SYNC) begin
				surr_ext_q <= 1'b1;
			end
		end
	end

	// interrupt level while an enabled detection flag stands
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= ctrl_q[serr_pkg::CT_IRQ] & (burst_q | surr_q);
		end
	end
endmodule // serr_top

// *** verif/serr_checker.sv ***
// checker: port level properties of the error and status stage
`timescale 1ns/100ps
module serr_checker #(
	parameter int unsigned WIDTH = 24
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic SUB_VALID,
	input wire logic SUB_PAR_ERR,
	input wire logic SUB_VBIT,
	input wire logic SUB_UBIT,
	input wire logic PLL_LOCKED,
	input wire logic [7:0] FS_RESULT,
	input wire logic FRAME_WORD_CLOCK,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic [WIDTH-1:0] AUDIO_WORD,
	input wire logic AUDIO_STROBE,
	input wire logic AUDIO_RIGHT,
	input wire logic LOCK_FAULT_FLAG,
	input wire logic [7:0] FS_OUT,
	input wire logic VALIDITY_OUT,
	input wire logic USER_BIT_OUT,
	input wire logic CHAN_STATUS_SERIAL_OUT,
	input wire logic IRQ_OUT
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	// fs result path
	property p_fs_zero;
		!PLL_LOCKED |=> FS_OUT == 8'h00;
	endproperty
	a_fs_zero: assert property (p_fs_zero)
		else $error("fs result not cleared while unlocked");
	property p_fs_live;
		PLL_LOCKED |=> FS_OUT == $past(FS_RESULT);
	endproperty
	a_fs_live: assert property (p_fs_live)
		else $error("fs result not presented while locked");
	// per subframe flags
	property p_flags_low;
		!PLL_LOCKED && SUB_VALID |=>
			!VALIDITY_OUT && !USER_BIT_OUT && !CHAN_STATUS_SERIAL_OUT;
	endproperty
	a_flags_low: assert property (p_flags_low)
		else $error("status flags live while unlocked");
	property p_vu_live;
		SUB_VALID && PLL_LOCKED && !SUB_PAR_ERR |=>
			VALIDITY_OUT == $past(SUB_VBIT) && USER_BIT_OUT == $past(SUB_UBIT);
	endproperty
	a_vu_live: assert property (p_vu_live)
		else $error("validity or user bit not passed on");
	// audio words follow the word clock, muted under faults; read data idles at zero
	property p_strobe_src;
		AUDIO_STROBE |-> $past(FRAME_WORD_CLOCK) != $past(FRAME_WORD_CLOCK, 2)
			&& AUDIO_RIGHT == $past(FRAME_WORD_CLOCK);
	endproperty
	a_strobe_src: assert property (p_strobe_src)
		else $error("audio strobe without word clock edge");
	property p_fault_mute;
		$past(LOCK_FAULT_FLAG) && AUDIO_STROBE |-> AUDIO_WORD == '0;
	endproperty
	a_fault_mute: assert property (p_fault_mute)
		else $error("audio word not muted during fault");
	property p_unlock_mute;
		!$past(PLL_LOCKED) && AUDIO_STROBE |-> AUDIO_WORD == '0;
	endproperty
	a_unlock_mute: assert property (p_unlock_mute)
		else $error("audio word not muted while unlocked");
	property p_rd_idle;
		!$past(REG_RD) |-> REG_RDATA == 32'h00000000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	c_fault: cover property ($rose(LOCK_FAULT_FLAG));
	c_irq: cover property ($rose(IRQ_OUT));
	c_right: cover property (AUDIO_STROBE && AUDIO_RIGHT);
endmodule // serr_checker
bind serr_top serr_checker #(.WIDTH(WIDTH)) i_serr_checker (.CLOCK, .RESETN,
	.SUB_VALID, .SUB_PAR_ERR, .SUB_VBIT, .SUB_UBIT, .PLL_LOCKED, .FS_RESULT,
	.FRAME_WORD_CLOCK, .REG_RD, .REG_RDATA, .AUDIO_WORD, .AUDIO_STROBE,
	.AUDIO_RIGHT, .LOCK_FAULT_FLAG, .FS_OUT, .VALIDITY_OUT, .USER_BIT_OUT,
	.CHAN_STATUS_SERIAL_OUT, .IRQ_OUT);

// *** verif/serr_sink.sv ***
// partner: downstream audio sink keeping the last word of each channel
`timescale 1ns/100ps
module serr_sink #(
	parameter int unsigned WIDTH = 24
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic strobe,
	input wire logic right,
	input wire logic [WIDTH-1:0] word,
	output logic [WIDTH-1:0] left_q,
	output logic [WIDTH-1:0] right_q,
	output logic [15:0] count_q
);
	// take every strobed word; a real dsp never stalls the stage either
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			left_q <= '0;
			right_q <= '0;
			count_q <= 16'h0000;
		end else if (strobe) begin
			if (right)
				right_q <= word;
			else
				left_q <= word;
			count_q <= count_q + 16'h0001;
		end
	end
endmodule // serr_sink

// *** verif/test_serr_top.sv ***
// testbench: scenarios for the error handling and status stage
`timescale 1ns/100ps
module test_serr_top;
	localparam int unsigned W = 24;
	logic CLOCK = 1'b0;
	logic RESETN, SUB_VALID, SUB_RIGHT, SUB_BLOCK, SUB_PAR_ERR, SUB_VBIT;
	logic SUB_UBIT, SUB_CBIT, PLL_LOCKED, PREAMBLES_SEEN, FRAME_WORD_CLOCK;
	logic BURST_SYNC, SURR_SYNC, SURR_BASE_OK, SURR_EXT_SYNC, TX_BLOCK_SYNC;
	logic CLOCK_SWITCH_IN, REG_WR, REG_RD, AUDIO_STROBE, AUDIO_RIGHT;
	logic LOCK_FAULT_FLAG, NONAUDIO_FLAG, PREEMPH_FLAG_OUT, VALIDITY_OUT;
	logic USER_BIT_OUT, CHAN_STATUS_SERIAL_OUT, AUDIO_VALIDITY_PIN;
	logic EMPH_USER_CS_PIN, BLOCK_START_OUT, IRQ_OUT;
	logic [W-1:0] SUB_DATA, AUDIO_WORD, snk_l, snk_r;
	logic [7:0] FS_RESULT, FS_OUT, REG_ADDR;
	logic [31:0] REG_WDATA, REG_RDATA;
	logic [15:0] snk_n;
	int num_errors = 0;
	int compares = 0;
	// short hold so a fault clears within a few frames
	serr_top #(.WIDTH(W), .HOLD_CYC(20)) i_serr_top (.CLOCK, .RESETN,
		.SUB_VALID, .SUB_RIGHT, .SUB_BLOCK, .SUB_DATA, .SUB_PAR_ERR, .SUB_VBIT,
		.SUB_UBIT, .SUB_CBIT, .PLL_LOCKED, .PREAMBLES_SEEN, .FS_RESULT,
		.FRAME_WORD_CLOCK, .BURST_SYNC, .SURR_SYNC, .SURR_BASE_OK,
		.SURR_EXT_SYNC, .TX_BLOCK_SYNC, .CLOCK_SWITCH_IN, .REG_ADDR, .REG_WDATA,
		.REG_WR, .REG_RD, .REG_RDATA, .AUDIO_WORD, .AUDIO_STROBE, .AUDIO_RIGHT,
		.LOCK_FAULT_FLAG, .FS_OUT, .NONAUDIO_FLAG, .PREEMPH_FLAG_OUT,
		.VALIDITY_OUT, .USER_BIT_OUT, .CHAN_STATUS_SERIAL_OUT,
		.AUDIO_VALIDITY_PIN, .EMPH_USER_CS_PIN, .BLOCK_START_OUT, .IRQ_OUT);
	serr_sink #(.WIDTH(W)) i_serr_sink (.clock(CLOCK), .resetn(RESETN),
		.strobe(AUDIO_STROBE), .right(AUDIO_RIGHT), .word(AUDIO_WORD),
		.left_q(snk_l), .right_q(snk_r), .count_q(snk_n));
	always #4 CLOCK = ~CLOCK;
	task automatic chk(input logic [31:0] seen, exp, input string msg);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s: %h not %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLOCK);
		REG_WR <= 1'b0;
		@(posedge CLOCK);
	endtask
	// read data is looked at in the one cycle it stands
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLOCK);
		REG_RD <= 1'b0;
		@(posedge CLOCK);
		chk(REG_RDATA, exp, "register read");
	endtask
	task automatic sf(input logic r, e, input logic [W-1:0] d,
		input logic v, c, b);
		{SUB_RIGHT, SUB_PAR_ERR, SUB_VBIT, SUB_UBIT, SUB_CBIT} <= {r, e, v, v, c};
		SUB_DATA <= d;
		SUB_BLOCK <= b;
		SUB_VALID <= 1'b1;
		@(posedge CLOCK);
		SUB_VALID <= 1'b0;
		@(posedge CLOCK);
	endtask
	task automatic fr(input logic e, input logic [W-1:0] dl, dr,
		input logic c, v);
		sf(1'b0, e, dl, v, c, 1'b0);
		sf(1'b1, e, dr, v, c, 1'b0);
	endtask
	// one word clock edge, then let the sink capture the word
	task automatic wc(input logic l);
		FRAME_WORD_CLOCK <= l;
		repeat (3) @(posedge CLOCK);
	endtask
	task automatic recover();
		fr(1'b0, 24'habcdef, 24'h123456, 1'b0, 1'b0);
		for (int i = 0; i < 20 && LOCK_FAULT_FLAG !== 1'b0; i++)
			wc(!FRAME_WORD_CLOCK);
		chk(LOCK_FAULT_FLAG, 0, "fault flag stuck");
		chk(snk_l, 0, "audio before resume edge");
		wc(!FRAME_WORD_CLOCK);
		wc(!FRAME_WORD_CLOCK);
		chk(snk_l, 24'habcdef, "left after resume");
		chk(snk_r, 24'h123456, "right after resume");
	endtask
	task automatic t_regs();
		rd(serr_pkg::OFS_CTRL, 32'h00000000);
		rd(serr_pkg::OFS_STATUS, 32'h00000000);
		wr(serr_pkg::OFS_CTRL, 32'h00000044);
		wr(8'hfc, 32'hffffffff);
		rd(serr_pkg::OFS_CTRL, 32'h00000044);
		rd(8'hfc, 32'h00000000);
		rd(serr_pkg::OFS_FS, 32'h0000005a);
		$display("regs done");
	endtask
	task automatic t_pcm();
		sf(1'b0, 1'b0, 24'h111111, 1'b1, 1'b0, 1'b0);
		chk(VALIDITY_OUT, 1, "validity bit");
		chk(USER_BIT_OUT, 1, "user bit");
		sf(1'b1, 1'b0, 24'h222222, 1'b0, 1'b0, 1'b0);
		chk(VALIDITY_OUT, 0, "validity clear");
		wc(1'b0);
		wc(1'b1);
		chk(snk_r, 24'h222222, "right word");
		fr(1'b1, 24'h333333, 24'h444444, 1'b0, 1'b1);
		chk(VALIDITY_OUT, 1, "validity in short run");
		rd(serr_pkg::OFS_STATUS, 32'h00000020);
		wc(1'b0);
		chk(snk_l, 24'h111111, "left substitute");
		wc(1'b1);
		chk(snk_r, 24'h222222, "right substitute");
		fr(1'b0, 24'h555555, 24'h666666, 1'b0, 1'b0);
		rd(serr_pkg::OFS_STATUS, 32'h00000000);
		$display("pcm done");
	endtask
	task automatic t_npcm();
		sf(1'b0, 1'b0, 24'h000000, 1'b0, 1'b0, 1'b1);
		sf(1'b1, 1'b0, 24'h000000, 1'b0, 1'b0, 1'b0);
		fr(1'b0, 24'h000000, 24'h000000, 1'b1, 1'b0);
		chk(NONAUDIO_FLAG, 1, "non-audio flag");
		wr(serr_pkg::OFS_CTRL, 32'h00000041);
		BURST_SYNC <= 1'b1;
		repeat (3) @(posedge CLOCK);
		BURST_SYNC <= 1'b0;
		chk(IRQ_OUT, 1, "burst interrupt");
		rd(serr_pkg::OFS_STATUS, 32'h00000002);
		wr(serr_pkg::OFS_CTRL, 32'h00000001);
		repeat (2) @(posedge CLOCK);
		chk(IRQ_OUT, 0, "masked interrupt");
		fr(1'b1, 24'h777777, 24'h888888, 1'b0, 1'b0);
		wc(1'b0);
		chk(snk_l, 24'h777777, "left passed as is");
		wc(1'b1);
		chk(snk_r, 24'h888888, "right passed as is");
		$display("non-pcm done");
	endtask
	// shared pins; pin outputs lag the status outputs by one cycle
	task automatic t_pins();
		wr(serr_pkg::OFS_CTRL, 32'h00000020);
		sf(1'b0, 1'b0, 24'h000000, 1'b1, 1'b1, 1'b1);
		@(posedge CLOCK);
		chk(EMPH_USER_CS_PIN, 1, "status bit on pin");
		chk(BLOCK_START_OUT, 1, "block start at bit 0");
		sf(1'b1, 1'b0, 24'h000000, 1'b1, 1'b0, 1'b0);
		@(posedge CLOCK);
		chk(EMPH_USER_CS_PIN, 0, "status bit low");
		chk(BLOCK_START_OUT, 0, "block start after bit 0");
		wr(serr_pkg::OFS_CTRL, 32'h00000028);
		@(posedge CLOCK);
		chk(EMPH_USER_CS_PIN, 0, "user select ignored");
		TX_BLOCK_SYNC <= 1'b1;
		wr(serr_pkg::OFS_CTRL, 32'h00000018);
		@(posedge CLOCK);
		chk(EMPH_USER_CS_PIN, 1, "user bit on pin");
		chk(BLOCK_START_OUT, 1, "transmit sync on pin");
		TX_BLOCK_SYNC <= 1'b0;
		$display("pins done");
	endtask
	task automatic t_long();
		repeat (5) fr(1'b1, 24'h999999, 24'h999999, 1'b1, 1'b1);
		chk(VALIDITY_OUT, 0, "validity forced");
		chk(USER_BIT_OUT, 0, "user forced");
		chk(CHAN_STATUS_SERIAL_OUT, 0, "status forced");
		chk(FS_OUT, 8'h5a, "fs kept");
		wc(1'b0);
		chk(LOCK_FAULT_FLAG, 1, "fault on long run");
		chk(snk_l, 0, "muted word");
		rd(serr_pkg::OFS_STATUS, 32'h000000c1);
		recover();
		$display("long run done");
	endtask
	task automatic t_unlock();
		PLL_LOCKED <= 1'b0;
		PREAMBLES_SEEN <= 1'b0;
		sf(1'b0, 1'b0, 24'h010101, 1'b1, 1'b1, 1'b0);
		chk(VALIDITY_OUT, 0, "validity unlocked");
		chk(CHAN_STATUS_SERIAL_OUT, 0, "status unlocked");
		chk(FS_OUT, 0, "fs unlocked");
		wc(!FRAME_WORD_CLOCK);
		chk(LOCK_FAULT_FLAG, 1, "fault on unlock");
		PLL_LOCKED <= 1'b1;
		PREAMBLES_SEEN <= 1'b1;
		recover();
		$display("unlock done");
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog: tests need a few thousand cycles at most
	initial begin
		#200000;
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		results();
	end
	initial begin
		{SUB_VALID, SUB_RIGHT, SUB_BLOCK, SUB_PAR_ERR, SUB_VBIT} = '0;
		{SUB_UBIT, SUB_CBIT, BURST_SYNC, SURR_SYNC, SURR_BASE_OK} = '0;
		{SURR_EXT_SYNC, TX_BLOCK_SYNC, CLOCK_SWITCH_IN, REG_WR, REG_RD} = '0;
		{PLL_LOCKED, PREAMBLES_SEEN} = 2'h3;
		FRAME_WORD_CLOCK = 1'b0; // matches the edge detector's reset level
		{RESETN, SUB_DATA, REG_ADDR, REG_WDATA} = '0;
		FS_RESULT = 8'h5a;
		repeat (5) @(posedge CLOCK);
		RESETN <= 1'b1;
		@(posedge CLOCK);
		t_regs();
		t_pcm();
		t_pins();
		t_npcm();
		t_long();
		t_unlock();
		results();
	end
endmodule // test_serr_top
